// [design/crf_pkg.sv]
// Shared constants, types and address decoding for the CPU register file block.
// Assumes one system clock and that every user of these names imports the whole package.
package crf_pkg;

  // ****************************************************************
  // Data-space map
  // ****************************************************************
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] SRAM_END = 16'h00DF;
  localparam int SRAM_DEPTH = 128;
  localparam int REG_COUNT = 32;
  localparam logic [5:0] IO_STACK_PTR = 6'h3D;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  localparam int STATUS_GIE_BIT = 7;
  localparam logic [7:0] STACK_PTR_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ****************************************************************
  // Register indices, program counter and interrupts
  // ****************************************************************
  localparam logic [4:0] PTR_A_LO = 5'h1A;
  localparam logic [4:0] PTR_B_LO = 5'h1C;
  localparam logic [4:0] PTR_C_LO = 5'h1E;
  localparam logic [4:0] PTR_HI_STEP = 5'h01;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [7:0] STACK_STEP = 8'h01;
  localparam int PC_W = 10;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam int IRQ_COUNT = 8;
  localparam int SRAM_ACCESS_CYCLES = 2;

  // Operation kinds presented by the instruction decoder.
  typedef enum logic [3:0] {
    OP_REG2 = 4'b0000, OP_IMM = 4'b0001, OP_REG1 = 4'b0010, OP_IN = 4'b0011,
    OP_OUT = 4'b0100, OP_LDS = 4'b0101, OP_STS = 4'b0110, OP_LD = 4'b0111,
    OP_ST = 4'b1000, OP_CALL = 4'b1001
  } crf_op_t;

  // Indirect addressing modes.
  typedef enum logic [1:0] {
    AM_PLAIN = 2'b00, AM_DISP = 2'b01, AM_PREDEC = 2'b10, AM_POSTINC = 2'b11
  } crf_amode_t;

  // Data-space regions.
  typedef enum logic [1:0] {
    RGN_REG = 2'b00, RGN_IO = 2'b01, RGN_SRAM = 2'b10, RGN_NONE = 2'b11
  } crf_region_t;

  // Sorts a data-space address into its region.
  function automatic crf_region_t crf_region(input logic [15:0] a);
    if (a < IO_BASE) return RGN_REG;
    if (a < SRAM_BASE) return RGN_IO;
    if (a <= SRAM_END) return RGN_SRAM;
    return RGN_NONE;
  endfunction

  // Low register index of a pointer pair; code 3 falls back to the third pair.
  function automatic logic [4:0] crf_ptr_lo(input logic [1:0] sel);
    if (sel == 2'b00) return PTR_A_LO;
    if (sel == 2'b01) return PTR_B_LO;
    return PTR_C_LO;
  endfunction

endpackage

// [design/crf_fetch.sv]
// Two-stage program fetch: holds the program counter and the fetched instruction word.
// Assumes program memory answers combinationally for the address it is given.
`timescale 1ns/1ps
`default_nettype none
module crf_fetch
  import crf_pkg::*;
(
  input wire logic clk,              // System clock.
  input wire logic rst_n,            // Synchronised reset, active low.
  input wire logic stall,            // Hold fetch while execution is busy.
  input wire logic load,             // Load a new program counter.
  input wire logic [PC_W-1:0] target, // New program counter value.
  input wire logic [15:0] pm_data,   // Word read at pm_addr.
  output logic [PC_W-1:0] pm_addr,   // Program memory word address.
  output logic [15:0] instr,         // Instruction handed to execution.
  output logic instr_valid,          // Instruction word is meaningful.
  output logic [PC_W-1:0] pc_next    // Address of the word being fetched.
);

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [15:0] instr;
    logic valid;
  } crf_fetch_t;

  crf_fetch_t q, n;

  // Fetch the next word while the current one executes; a load flushes the stage.
  always_comb begin
    n = q;
    if (load) begin
      n.pc = target;
      n.valid = 1'b0;
    end else if (!stall) begin
      n.instr = pm_data;
      n.valid = 1'b1;
      n.pc = q.pc + PC_STEP;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{pc: PC_RESET, instr: 16'h0000, valid: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign pm_addr = q.pc;
  assign instr = q.instr;
  assign instr_valid = q.valid;
  assign pc_next = q.pc;

  pc_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!stall && !load) |=> (instr_valid && pc_next == $past(pc_next) + PC_STEP))
    else $error("Fetch did not advance on a free cycle.");

endmodule
`default_nettype wire

// [design/crf_irq.sv]
// Interrupt arbiter: picks the pending source with the lowest vector address.
// Assumes pending lines come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module crf_irq
  import crf_pkg::*;
(
  input wire logic clk,                 // System clock.
  input wire logic rst_n,               // Synchronised reset, active low.
  input wire logic [IRQ_COUNT-1:0] pend, // Pending sources, bit 0 highest priority.
  input wire logic gie,                 // Global interrupt enable.
  output logic req,                     // An enabled source is pending.
  output logic [PC_W-1:0] vector        // Vector word address of the winner.
);

  typedef struct packed {
    logic req;
    logic [PC_W-1:0] vec;
  } crf_irq_t;

  crf_irq_t q, n;

  // Scan from the highest index down so the lowest pending index wins.
  always_comb begin
    n.req = gie && (pend != '0);
    n.vec = q.vec;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        n.vec = PC_W'(i);
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{req: 1'b0, vec: PC_RESET};
    end else begin
      q <= n;
    end
  end

  assign req = q.req;
  assign vector = q.vec;

  lowest_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (gie && pend[0]) |=> (req && vector == PC_RESET))
    else $error("Lowest vector did not win arbitration.");

endmodule
`default_nettype wire

// [design/crf_top.sv]
// CPU working register file with data-space decode, stack push, fetch and interrupt arbitration.
// Assumes the decoder, ALU and peripheral registers all run on CLK and answer in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module crf_top
  import crf_pkg::*;
(
  input wire logic CLK,                    // System clock, 25 MHz.
  input wire logic RST_B,                  // Asynchronous reset, active low.
  input wire logic OP_VALID,               // Decoder presents an operation.
  output logic OP_READY,                   // Block accepts an operation this cycle.
  input wire logic [3:0] OP_KIND,          // Operation kind code.
  input wire logic [4:0] OP_DEST,          // dest_reg index.
  input wire logic [4:0] OP_SRC,           // source_reg index.
  input wire logic [7:0] OP_IMM,           // Immediate constant.
  input wire logic [5:0] OP_IO,            // I/O location number.
  input wire logic [15:0] OP_ADDR,         // Data direct address (second word).
  input wire logic [1:0] OP_PTR,           // Pointer select: a, b, c.
  input wire logic [1:0] OP_MODE,          // Indirect addressing mode.
  input wire logic [5:0] OP_DISP,          // Unsigned displacement.
  input wire logic OP_WB,                  // Write ALU result back to dest_reg.
  output logic [7:0] ALU_A,                // First ALU operand.
  output logic [7:0] ALU_B,                // Second ALU operand.
  input wire logic [7:0] ALU_RESULT,       // ALU result of this cycle.
  output logic [5:0] IO_ADDR,              // Peripheral register number.
  output logic IO_WE,                      // Peripheral write strobe.
  output logic IO_RE,                      // Peripheral read strobe.
  output logic [7:0] IO_WDATA,             // Peripheral write data.
  input wire logic [7:0] IO_RDATA,         // Peripheral read data.
  input wire logic PC_LOAD,                // Load the program counter.
  input wire logic [PC_W-1:0] PC_TARGET,   // Program counter load value.
  output logic [PC_W-1:0] PM_ADDR,         // Program memory word address.
  input wire logic [15:0] PM_DATA,         // Program memory word.
  output logic [15:0] INSTR,               // Fetched instruction.
  output logic INSTR_VALID,                // Fetched instruction is valid.
  input wire logic [IRQ_COUNT-1:0] IRQ_PEND, // Pending interrupt sources.
  output logic IRQ_REQ,                    // Enabled interrupt pending.
  output logic [PC_W-1:0] IRQ_VECTOR,      // Vector of the winning source.
  output logic [7:0] STACK_TOP_POINTER     // Current stack_top_pointer.
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MEM = 2'b01, ST_PUSH_HI = 2'b10
  } crf_state_t;

  typedef struct packed {
    crf_state_t st;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [SRAM_DEPTH-1:0][7:0] sram;
    logic [7:0] sp;
    logic [7:0] status;
    logic [15:0] maddr;
    logic mwrite;
    logic [4:0] mreg;
    logic [7:0] mdata;
    logic [7:0] hi_byte;
    logic push_more;
  } crf_core_t;

  crf_core_t q, n;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic busy;
  logic [PC_W-1:0] ret_pc;
  logic [4:0] dsel, plo, acc_dest;
  logic [15:0] ptr_val, eff_addr, acc_addr, io_ofs, sram_ofs;
  logic acc_go, acc_wr, acc_ld;
  logic [7:0] acc_wd, acc_rd, alu_a_c, alu_b_c, io_wd_c;
  logic [5:0] io_addr_c;
  logic io_we_c, io_re_c;
  crf_region_t rgn;
  crf_op_t kind;
  crf_amode_t mode;

  // ****************************************************************
  // Reset release
  // ****************************************************************

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Operand selection and addressing
  // ****************************************************************
  assign kind = crf_op_t'(OP_KIND);
  assign mode = crf_amode_t'(OP_MODE);
  assign busy = (q.st != ST_IDLE);

  // Immediate operations reach only the upper half; pointers pair two registers.
  always_comb begin
    dsel = (kind == crf_pkg::OP_IMM) ? {1'b1, OP_DEST[3:0]} : OP_DEST;
    plo = crf_ptr_lo(OP_PTR);
    ptr_val = {q.regs[plo + PTR_HI_STEP], q.regs[plo]};
    alu_a_c = q.regs[dsel];
    unique case (kind)
      OP_REG2: alu_b_c = q.regs[OP_SRC];
      crf_pkg::OP_IMM: alu_b_c = OP_IMM;
      default: alu_b_c = 8'h00;
    endcase
    unique case (mode)
      AM_DISP: eff_addr = ptr_val + {10'h000, OP_DISP};
      AM_PREDEC: eff_addr = ptr_val - PTR_STEP;
      default: eff_addr = ptr_val;
    endcase
  end

  // ****************************************************************
  // Execution, data-space access and stack push
  // ****************************************************************

  // Accept an operation, route its data access, and sequence two-cycle SRAM accesses.
  always_comb begin
    n = q;
    acc_go = 1'b0;
    acc_wr = 1'b0;
    acc_ld = 1'b0;
    acc_addr = eff_addr;
    acc_wd = q.regs[OP_DEST];
    acc_dest = OP_DEST;
    acc_rd = 8'h00;
    io_addr_c = 6'h00;
    io_we_c = 1'b0;
    io_re_c = 1'b0;
    io_wd_c = 8'h00;
    unique case (q.st)
      ST_IDLE: begin
        if (OP_VALID) begin
          unique case (kind)
            OP_REG2, crf_pkg::OP_IMM, OP_REG1: begin
              if (OP_WB) begin
                n.regs[dsel] = ALU_RESULT;
              end
            end
            OP_IN, OP_OUT: begin
              acc_go = 1'b1;
              acc_ld = (kind == OP_IN);
              acc_wr = (kind == OP_OUT);
              acc_addr = IO_BASE + {10'h000, OP_IO};
            end
            OP_LDS, OP_STS: begin
              acc_go = 1'b1;
              acc_ld = (kind == OP_LDS);
              acc_wr = (kind == OP_STS);
              acc_addr = OP_ADDR;
            end
            OP_LD, OP_ST: begin
              acc_go = 1'b1;
              acc_ld = (kind == OP_LD);
              acc_wr = (kind == OP_ST);
              if (mode == AM_PREDEC) begin
                {n.regs[plo + PTR_HI_STEP], n.regs[plo]} = eff_addr;
              end else if (mode == AM_POSTINC) begin
                {n.regs[plo + PTR_HI_STEP], n.regs[plo]} = ptr_val + PTR_STEP;
              end
            end
            OP_CALL: begin
              n.st = ST_MEM;
              n.maddr = {8'h00, q.sp};
              n.mwrite = 1'b1;
              n.mdata = ret_pc[7:0];
              n.hi_byte = {6'h00, ret_pc[PC_W-1:8]};
              n.push_more = 1'b1;
              n.sp = q.sp - STACK_STEP;
            end
            default: begin
            end
          endcase
          // SRAM targets are held over to a second cycle.
          if (acc_go && crf_region(acc_addr) == RGN_SRAM) begin
            n.st = ST_MEM;
            n.maddr = acc_addr;
            n.mwrite = acc_wr;
            n.mreg = OP_DEST;
            n.mdata = acc_wd;
            n.push_more = 1'b0;
            acc_go = 1'b0;
          end
        end
      end
      ST_MEM: begin
        acc_go = 1'b1;
        acc_addr = q.maddr;
        acc_wr = q.mwrite;
        acc_ld = !q.mwrite;
        acc_wd = q.mdata;
        acc_dest = q.mreg;
        n.st = ST_IDLE;
        if (q.push_more) begin
          n.st = ST_PUSH_HI;
          n.maddr = {8'h00, q.sp};
          n.mdata = q.hi_byte;
          n.push_more = 1'b0;
          n.sp = q.sp - STACK_STEP;
        end
      end
      ST_PUSH_HI: begin
        n.st = ST_MEM;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // Unified data-space decode shared by every addressing mode.
    rgn = crf_region(acc_addr);
    io_ofs = acc_addr - IO_BASE;
    sram_ofs = acc_addr - SRAM_BASE;
    if (acc_go) begin
      unique case (rgn)
        RGN_REG: begin
          acc_rd = q.regs[acc_addr[4:0]];
          if (acc_wr) begin
            n.regs[acc_addr[4:0]] = acc_wd;
          end
        end
        RGN_IO: begin
          if (io_ofs[5:0] == IO_STACK_PTR) begin
            acc_rd = q.sp;
            if (acc_wr) begin
              n.sp = acc_wd;
            end
          end else if (io_ofs[5:0] == IO_STATUS) begin
            acc_rd = q.status;
            if (acc_wr) begin
              n.status = acc_wd;
            end
          end else begin
            io_addr_c = io_ofs[5:0];
            io_re_c = acc_ld;
            io_we_c = acc_wr;
            io_wd_c = acc_wd;
            acc_rd = IO_RDATA;
          end
        end
        RGN_SRAM: begin
          acc_rd = q.sram[sram_ofs[6:0]];
          if (acc_wr) begin
            n.sram[sram_ofs[6:0]] = acc_wd;
          end
        end
        default: begin
          acc_rd = 8'h00;
        end
      endcase
      if (acc_ld) begin
        n.regs[acc_dest] = acc_rd;
      end
    end
  end

  // State register.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: ST_IDLE, regs: '0, sram: '0, sp: STACK_PTR_RESET, status: STATUS_RESET,
             maddr: 16'h0000, mwrite: 1'b0, mreg: 5'h00, mdata: 8'h00, hi_byte: 8'h00,
             push_more: 1'b0};
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Fetch, interrupts and outputs
  // ****************************************************************
  crf_fetch u_fetch (
    .clk(CLK),
    .rst_n(rst_n),
    .stall(busy),
    .load(PC_LOAD),
    .target(PC_TARGET),
    .pm_data(PM_DATA),
    .pm_addr(PM_ADDR),
    .instr(INSTR),
    .instr_valid(INSTR_VALID),
    .pc_next(ret_pc)
  );

  crf_irq u_irq (
    .clk(CLK),
    .rst_n(rst_n),
    .pend(IRQ_PEND),
    .gie(q.status[STATUS_GIE_BIT]),
    .req(IRQ_REQ),
    .vector(IRQ_VECTOR)
  );

  // Handshake, operand and peripheral outputs are combinational; the stack pointer comes from state.
  assign OP_READY = !busy;
  assign ALU_A = alu_a_c;
  assign ALU_B = alu_b_c;
  assign IO_ADDR = io_addr_c;
  assign IO_WE = io_we_c;
  assign IO_RE = io_re_c;
  assign IO_WDATA = io_wd_c;
  assign STACK_TOP_POINTER = q.sp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  reg_writeback_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && kind == OP_REG2 && OP_WB) |=> q.regs[$past(OP_DEST)] == $past(ALU_RESULT))
    else $error("ALU result not written to dest_reg.");

  imm_upper_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && kind == crf_pkg::OP_IMM && OP_WB && !OP_DEST[4])
    |=> q.regs[{1'b1, $past(OP_DEST[3:0])}] == $past(ALU_RESULT))
    else $error("Immediate result not placed in upper half.");

  sram_two_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && kind == OP_LDS && crf_region(OP_ADDR) == RGN_SRAM)
    |=> !OP_READY ##1 OP_READY)
    else $error("SRAM access did not take two cycles.");

  high_zero_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && kind == OP_LDS && OP_ADDR > SRAM_END) |=> q.regs[$past(OP_DEST)] == 8'h00)
    else $error("Unmapped read did not return zero.");

  post_inc_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && kind == OP_ST && mode == AM_POSTINC && crf_region(ptr_val) == RGN_SRAM)
    |=> {q.regs[$past(plo) + PTR_HI_STEP], q.regs[$past(plo)]} == $past(ptr_val) + PTR_STEP)
    else $error("Post-increment pointer not updated.");

  pre_dec_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && (kind == OP_LD || kind == OP_ST) && mode == AM_PREDEC
     && crf_region(eff_addr) == RGN_SRAM) |=> q.maddr == $past(ptr_val) - PTR_STEP)
    else $error("Pre-decrement address wrong.");

  call_push_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (OP_VALID && OP_READY && kind == OP_CALL) |=> ##2 (q.st == ST_MEM && q.sp == $past(q.sp, 3) - 8'h02))
    else $error("Call push did not step the stack pointer twice.");

endmodule
`default_nettype wire

// [verification/crf_peer.sv]
// Far-side model: adding ALU, peripheral registers and program memory.
// Assumes the block under test runs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module crf_peer (
  input wire logic clk, // Clock.
  input wire logic [7:0] a, // First operand.
  input wire logic [7:0] b, // Second operand.
  output logic [7:0] sum, // ALU result.
  input wire logic [5:0] ioa, // Peripheral number.
  input wire logic we, // Write strobe.
  input wire logic re, // Read strobe.
  input wire logic [7:0] wd, // Write data.
  output logic [7:0] rd, // Read data.
  input wire logic [9:0] pa, // Word address.
  output logic [15:0] pd // Program word.
);
  logic [7:0] io_q [64];
  logic [7:0] last_q = 8'h00;
  // Unselected read data shows the inverse of the last value, so a stale copy is never seen.
  assign sum = a + b;
  assign rd = re ? io_q[ioa] : ~last_q;
  assign pd = {6'h2a, pa};
  // Peripheral registers take writes on the rising edge.
  always @(posedge clk) begin
    if (we) io_q[ioa] <= wd;
    last_q <= rd;
  end
endmodule
`default_nettype wire

// [verification/crf_top_tb.sv]
// Self-checking bench for the register file block with its far-side model.
// Assumes crf_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module crf_top_tb;
  import crf_pkg::*;
  logic CLK = 1'b0, RST_B = 1'b0, OP_VALID = 1'b0, OP_WB = 1'b0, PC_LOAD = 1'b0, peek = 1'b0;
  logic OP_READY, IO_WE, IO_RE, INSTR_VALID, IRQ_REQ;
  logic [3:0] OP_KIND = 4'h0;
  logic [4:0] OP_DEST = 5'h00, OP_SRC = 5'h00;
  logic [7:0] OP_IMM = 8'h00, IRQ_PEND = 8'h00, ALU_A, ALU_B, ALU_RESULT, IO_WDATA, IO_RDATA, STACK_TOP_POINTER;
  logic [5:0] OP_IO = 6'h00, OP_DISP = 6'h00, IO_ADDR;
  logic [15:0] OP_ADDR = 16'h0000, PM_DATA, INSTR;
  logic [1:0] OP_PTR = 2'h0, OP_MODE = 2'h0;
  logic [9:0] PC_TARGET = 10'h000, PM_ADDR, IRQ_VECTOR;
  logic [7:0] exp_q [$];
  logic [7:0] rf [32];
  logic [15:0] adr [5] = '{16'h0005, 16'h0021, 16'h0060, 16'h00df, 16'h00e0};
  int n_mismatch = 0, comparisons = 0;
  integer seed = 32'hc1ec_4efa;
  crf_top dut_u (.CLK, .RST_B, .OP_VALID, .OP_READY, .OP_KIND, .OP_DEST, .OP_SRC, .OP_IMM, .OP_IO, .OP_ADDR,
    .OP_PTR, .OP_MODE, .OP_DISP, .OP_WB, .ALU_A, .ALU_B, .ALU_RESULT, .IO_ADDR, .IO_WE, .IO_RE, .IO_WDATA,
    .IO_RDATA, .PC_LOAD, .PC_TARGET, .PM_ADDR, .PM_DATA, .INSTR, .INSTR_VALID, .IRQ_PEND, .IRQ_REQ,
    .IRQ_VECTOR, .STACK_TOP_POINTER);
  crf_peer peer_u (.clk(CLK), .a(ALU_A), .b(ALU_B), .sum(ALU_RESULT), .ioa(IO_ADDR), .we(IO_WE), .re(IO_RE),
    .wd(IO_WDATA), .rd(IO_RDATA), .pa(PM_ADDR), .pd(PM_DATA));
  // ****************************************************************
  // Drivers and checking
  // ****************************************************************
  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 CLK = ~CLK;
  // Compares one result and reports a difference at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Offers one operation, holds it until taken, then drops it at the next falling edge.
  task automatic op(input logic [3:0] k, input logic [4:0] d, input logic [7:0] v, input logic [15:0] a,
                    input logic [1:0] m = AM_PLAIN, input logic p = 1'b0);
    int i;
    @(negedge CLK);
    PC_LOAD = 1'b0;
    OP_VALID = 1'b1;
    OP_KIND = k;
    OP_DEST = d;
    OP_SRC = (k == OP_REG2) ? v[4:0] : d;
    OP_IMM = v;
    OP_DISP = v[5:0];
    OP_ADDR = a;
    OP_IO = a[5:0];
    OP_PTR = a[1:0];
    OP_MODE = m;
    OP_WB = (k == OP_REG2 || k == crf_pkg::OP_IMM) && !p;
    peek = p;
    for (i = 0; i < 8 && OP_READY !== 1'b1; i++) @(negedge CLK);
    if (i == 8) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge CLK);
    @(negedge CLK);
    OP_VALID = 1'b0;
  endtask
  // Notes a register's expected value and shows it on the first operand.
  task automatic look(input logic [4:0] d);
    exp_q.push_back(rf[d]);
    op(OP_REG1, d, 8'h00, 16'h0000, AM_PLAIN, 1'b1);
  endtask
  // Loads an upper register with an exact value through the adding ALU.
  task automatic setr(input logic [4:0] r, input logic [7:0] x);
    op(crf_pkg::OP_IMM, r, x - rf[r], 16'h0000);
    rf[r] = x;
  endtask
  // The watcher takes the oldest note whenever an operand is shown.
  always @(posedge CLK) if (peek && OP_VALID && OP_READY) chk(ALU_A, exp_q.pop_front());
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i, d, s;
    logic [7:0] v;
    rf = '{default: 8'h00};
    repeat (8) @(posedge CLK);
    @(negedge CLK);
    RST_B = 1'b1;
    repeat (3) @(negedge CLK);
    chk(STACK_TOP_POINTER, STACK_PTR_RESET);
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      rf[16 + i] = v;
      op(crf_pkg::OP_IMM, i[4:0], v, 16'h0000);
      look(5'h10 + i[4:0]);
    end
    for (i = 0; i < 12; i++) begin
      d = {$random(seed)} % 32;
      s = {$random(seed)} % 32;
      rf[d] = rf[d] + rf[s];
      op(OP_REG2, d[4:0], s[7:0], 16'h0000);
      look(d[4:0]);
    end
    $display("test alu done");
    foreach (adr[i]) begin
      if (adr[i] < IO_BASE) rf[adr[i][4:0]] = rf[20];
      rf[1] = (adr[i] > SRAM_END) ? 8'h00 : rf[20];
      op(OP_STS, 5'h14, 8'h00, adr[i]);
      op(OP_LDS, 5'h01, 8'h00, adr[i]);
      chk(OP_READY, adr[i] < SRAM_BASE || adr[i] > SRAM_END);
      look(5'h01);
    end
    op(OP_OUT, 5'h11, 8'h00, 16'h0015);
    rf[2] = rf[17];
    op(OP_IN, 5'h02, 8'h00, 16'h0015);
    look(5'h02);
    $display("test map done");
    setr(5'h1c, 8'h80);
    setr(5'h1d, 8'h00);
    op(OP_ST, 5'h13, 8'h00, 16'h0001, AM_POSTINC);
    rf[28] = 8'h81;
    look(5'h1c);
    rf[3] = rf[19];
    rf[28] = 8'h80;
    op(OP_LD, 5'h03, 8'h00, 16'h0001, AM_PREDEC);
    look(5'h03);
    look(5'h1c);
    setr(5'h1e, 8'h41);
    setr(5'h1f, 8'h00);
    rf[4] = rf[19];
    op(OP_LD, 5'h04, 8'h3f, 16'h0002, AM_DISP);
    look(5'h04);
    setr(5'h1a, 8'h07);
    setr(5'h1b, 8'h00);
    rf[7] = rf[19];
    op(OP_ST, 5'h13, 8'h00, 16'h0000);
    look(5'h07);
    $display("test pointer done");
    @(negedge CLK);
    PC_LOAD = 1'b1;
    PC_TARGET = 10'h2c5;
    @(negedge CLK);
    PC_LOAD = 1'b0;
    chk(INSTR_VALID, 1'b0);
    @(negedge CLK);
    chk(INSTR, {6'h2a, 10'h2c5});
    chk(INSTR_VALID, 1'b1);
    chk(PM_ADDR, 10'h2c6);
    setr(5'h15, 8'hdf);
    op(OP_OUT, 5'h15, 8'h00, 16'h003d);
    chk(STACK_TOP_POINTER, 8'hdf);
    @(negedge CLK);
    PC_LOAD = 1'b1;
    op(OP_CALL, 5'h00, 8'h00, 16'h0000);
    repeat (4) @(negedge CLK);
    chk(STACK_TOP_POINTER, 8'hdd);
    rf[5] = 8'hc5;
    op(OP_LDS, 5'h05, 8'h00, 16'h00df);
    look(5'h05);
    rf[5] = 8'h02;
    op(OP_LDS, 5'h05, 8'h00, 16'h00de);
    look(5'h05);
    $display("test fetch and call done");
    setr(5'h16, 8'h80);
    op(OP_OUT, 5'h16, 8'h00, 16'h003f);
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      IRQ_PEND = (v | 8'h01) << i;
      @(negedge CLK);
      chk(IRQ_REQ, 1'b1);
      chk(IRQ_VECTOR, i[9:0]);
    end
    setr(5'h16, 8'h00);
    op(OP_OUT, 5'h16, 8'h00, 16'h003f);
    @(negedge CLK);
    chk(IRQ_REQ, 1'b0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
